// ==== design/adaptive_backlight_pwm_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the backlight block.
`ifndef ADAPTIVE_BACKLIGHT_PWM_REGS_SVH
`define ADAPTIVE_BACKLIGHT_PWM_REGS_SVH
`define ABL_ADDR_W 8
`define ABL_OFF_BRIGHT 8'h51
`define ABL_OFF_BRIGHT_RD 8'h52
`define ABL_OFF_CTRL 8'h53
`define ABL_OFF_CTRL_RD 8'h54
`define ABL_OFF_MODE 8'h55
`define ABL_OFF_MODE_RD 8'h56
`define ABL_OFF_MINFLOOR 8'h5E
`define ABL_OFF_MINFLOOR_RD 8'h5F
`define ABL_OFF_FORCE 8'hC0
`define ABL_OFF_FORCE_DUTY 8'hC1
`define ABL_OFF_STEPS 8'hC2
`define ABL_OFF_TIMING 8'hC3
`define ABL_OFF_PWMCFG 8'hC4
`define ABL_OFF_PWM_DIVIDER 8'hC5
`define ABL_OFF_PWMCNT 8'hC6
`define ABL_OFF_OFFSET 8'hC7
`define ABL_OFF_UI0 8'hC8
`define ABL_OFF_UI3 8'hCB
`define ABL_OFF_ADAPT 8'hCC
`define ABL_OFF_STATUS 8'hCD
`define ABL_CTRL_BACKLIGHT_CTRL_ENABLE_BIT 5
`define ABL_CTRL_DD_BIT 3
`define ABL_CTRL_BL_BIT 2
`define ABL_PWMCFG_POL_BIT 2
`define ABL_FULL_SCALE 8'hFF
`define ABL_ZERO 8'h00
`define ABL_RST_BYTE 8'h00
`define ABL_RST_PWM_DIVIDER 8'h01
`define ABL_RST_STEPS 9'h000
`define ABL_RST_TIMING 8'h11
`define ABL_PWM_BASE 9'h100
`define ABL_DIV_OSC10 4'd10
`define ABL_DIV_OSC5 4'd5
`define ABL_DIV_OSC2 4'd2
`define ABL_DIV_OSC1 4'd1
`endif

// ==== design/adaptive_backlight_pwm_pkg.sv ====
// Types shared by the backlight block.
package adaptive_backlight_pwm_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_UI,
    MODE_STILL,
    MODE_MOVING
  } adaptive_mode_t;
  typedef enum logic {
    DIM_IDLE,
    DIM_RAMP
  } dim_state_t;
endpackage

// ==== design/pwm_wave_gen.sv ====
// PWM waveform generator on a divided oscillator tick.
`timescale 1ns/1ps
`include "adaptive_backlight_pwm_regs.svh"
module pwm_wave_gen (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [1:0] clock_select_i,
  input wire logic [7:0] divider_i,
  input wire logic [7:0] duty_count_i,
  input wire logic [7:0] duty_i,
  output logic pwm_o
);
  logic [3:0] pre_r;
  logic [7:0] div_r;
  logic [8:0] cnt_r;
  logic tick;
  logic div_tick;
  logic [3:0] pre_max;
  logic [8:0] period_max;
  logic [8:0] high_len;

  // The counter clock is the oscillator divided by 10, 5, 2 or 1.
  always_comb begin
    case (clock_select_i)
      2'b00: pre_max = `ABL_DIV_OSC10 - 4'd1;
      2'b01: pre_max = `ABL_DIV_OSC5 - 4'd1;
      2'b10: pre_max = `ABL_DIV_OSC2 - 4'd1;
      default: pre_max = `ABL_DIV_OSC1 - 4'd1;
    endcase
  end

  assign tick = (pre_r >= pre_max);
  assign div_tick = tick && (div_r + 8'd1 >= divider_i);
  assign period_max = `ABL_PWM_BASE + {1'b0, duty_count_i} - 9'd1;
  assign high_len = {1'b0, duty_i} + {8'h00, duty_i != 8'h00};

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r <= 4'd0;
    end else if (tick) begin
      pre_r <= 4'd0;
    end else begin
      pre_r <= pre_r + 4'd1;
    end
  end

  // Each period counts (256 + count) steps of divider ticks.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r <= 8'd0;
      cnt_r <= 9'd0;
    end else if (tick) begin
      if (div_tick) begin
        div_r <= 8'd0;
        cnt_r <= (cnt_r >= period_max) ? 9'd0 : cnt_r + 9'd1;
      end else begin
        div_r <= div_r + 8'd1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= (cnt_r < high_len);
    end
  end
endmodule

// ==== design/adaptive_backlight_pwm.sv ====
// Adaptive backlight duty combiner, dimming engine and register port.
// How it works
// - Duty equals manual ratio times adaptive ratio.
// - Gate off holds polarity; on gives PWM.
// - Enable cleared ramps off; readback becomes zero.
// - Off mode without forcing uses full scale.
// - Other modes multiply manual by adaptive ratio.
// - Write brightness at 51h; 52h reads actual duty.
// - Target never falls below minimum floor, except when enable cleared or sleep-in forces it to zero.
// - Force enable replaces adaptive ratio with constant.
// - Sleep-in: flag zero, adaptive off, backlight off.
// - Dimming enable selects ramped or immediate changes.
// - Step count per mode; rise/fall timing.
// - Timing is frames per step; counts are steps.
// - Clock select divides oscillator by 10,5,2,1.
// - Period is (256+count) times divider; offset compensates.
// - Mode field written with command 55h.
// - UI mode uses four preferred level registers.
// - Still mode ratio follows image content.
// - Brightness, control and mode writes take effect at next frame start.
`timescale 1ns/1ps
`include "adaptive_backlight_pwm_regs.svh"
module adaptive_backlight_pwm (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic frame_start_i,
  input wire logic sleep_out_i,
  input wire logic [7:0] content_ratio_i,
  output logic backlight_pwm_out_o,
  output logic sleep_out_flag_o
);
  // Shadow registers written by software; ui_sel_r is latched from content at frame start.
  logic [7:0] brightness_value_r;
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] min_duty_floor_r;
  logic force_duty_enable_r;
  logic [7:0] forced_duty_value_r;
  logic [8:0] steps_r;
  logic [7:0] timing_r;
  logic [7:0] pwmcfg_r;
  logic [7:0] pwm_divider_r;
  logic [7:0] pwm_count_r;
  logic [4:0] offset_r;
  logic [7:0] ui_preferred_level_r [0:3];
  logic [1:0] ui_sel_r;
  // Frame-synchronised copies that steer the logic.
  logic [7:0] act_bright_r;
  logic act_backlight_ctrl_enable_r;
  logic act_dd_r;
  logic act_gate_r;
  adaptive_backlight_pwm_pkg::adaptive_mode_t act_mode_r;
  // Synchronised pins.
  logic frame_m_r;
  logic frame_s_r;
  logic frame_d_r;
  logic sleep_m_r;
  logic sleep_s_r;
  logic [7:0] content_m_r;
  logic [7:0] content_s_r;
  // Dimming engine.
  adaptive_backlight_pwm_pkg::dim_state_t dim_state_r;
  logic [7:0] duty_r;
  logic [7:0] step_size_r;
  logic [3:0] frame_cnt_r;
  logic [7:0] duty_out_r;
  logic frame_tick;
  logic [7:0] adaptive_ratio;
  logic [7:0] manual_ratio;
  logic [7:0] target;
  logic [2:0] mode_steps;
  logic [3:0] fpstep;
  logic rising;

  function automatic logic [7:0] mul_ratio(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    p = a * b + {8'h00, a};
    return p[15:8];
  endfunction

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [4:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {4'h0, b};
    return s[8] ? `ABL_FULL_SCALE : s[7:0];
  endfunction

  assign frame_tick = frame_s_r && !frame_d_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_m_r <= 1'b0;
      frame_s_r <= 1'b0;
      frame_d_r <= 1'b0;
      sleep_m_r <= 1'b0;
      sleep_s_r <= 1'b0;
      content_m_r <= `ABL_FULL_SCALE;
      content_s_r <= `ABL_FULL_SCALE;
    end else begin
      frame_m_r <= frame_start_i;
      frame_s_r <= frame_m_r;
      frame_d_r <= frame_s_r;
      sleep_m_r <= sleep_out_i;
      sleep_s_r <= sleep_m_r;
      content_m_r <= content_ratio_i;
      content_s_r <= content_m_r;
    end
  end

  // Software writes into the shadow registers.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brightness_value_r <= `ABL_RST_BYTE;
      ctrl_r <= `ABL_RST_BYTE;
      mode_r <= `ABL_RST_BYTE;
      min_duty_floor_r <= `ABL_RST_BYTE;
      force_duty_enable_r <= 1'b0;
      forced_duty_value_r <= `ABL_RST_BYTE;
      steps_r <= `ABL_RST_STEPS;
      timing_r <= `ABL_RST_TIMING;
      pwmcfg_r <= `ABL_RST_BYTE;
      pwm_divider_r <= `ABL_RST_PWM_DIVIDER;
      pwm_count_r <= `ABL_RST_BYTE;
      offset_r <= 5'd0;
      for (int i = 0; i < 4; i++) begin
        ui_preferred_level_r[i] <= `ABL_FULL_SCALE;
      end
    end else if (wr_i) begin
      if (addr_i == `ABL_OFF_BRIGHT) begin
        brightness_value_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_CTRL) begin
        ctrl_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_MODE) begin
        mode_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_MINFLOOR) begin
        min_duty_floor_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_FORCE) begin
        force_duty_enable_r <= wdata_i[0];
      end else if (addr_i == `ABL_OFF_FORCE_DUTY) begin
        forced_duty_value_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_STEPS) begin
        steps_r <= {wdata_i[0], wdata_i};
      end else if (addr_i == `ABL_OFF_TIMING) begin
        timing_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_PWMCFG) begin
        pwmcfg_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_PWM_DIVIDER) begin
        pwm_divider_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_PWMCNT) begin
        pwm_count_r <= wdata_i;
      end else if (addr_i == `ABL_OFF_OFFSET) begin
        offset_r <= wdata_i[4:0];
      end else if (addr_i >= `ABL_OFF_UI0 && addr_i <= `ABL_OFF_UI3) begin
        ui_preferred_level_r[addr_i[1:0]] <= wdata_i;
      end
    end
  end

  // Shadow values become active at the next frame start.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_bright_r <= `ABL_RST_BYTE;
      act_backlight_ctrl_enable_r <= 1'b0;
      act_dd_r <= 1'b0;
      act_gate_r <= 1'b0;
      act_mode_r <= adaptive_backlight_pwm_pkg::MODE_OFF;
      ui_sel_r <= 2'd0;
    end else if (frame_tick) begin
      act_bright_r <= brightness_value_r;
      act_backlight_ctrl_enable_r <= ctrl_r[`ABL_CTRL_BACKLIGHT_CTRL_ENABLE_BIT];
      act_dd_r <= ctrl_r[`ABL_CTRL_DD_BIT];
      act_gate_r <= ctrl_r[`ABL_CTRL_BL_BIT];
      act_mode_r <= adaptive_backlight_pwm_pkg::adaptive_mode_t'(mode_r[1:0]);
      ui_sel_r <= content_s_r[7:6];
    end
  end

  // Adaptive ratio selection per mode.
  always_comb begin
    adaptive_ratio = `ABL_FULL_SCALE;
    if (!sleep_s_r) begin
      adaptive_ratio = `ABL_FULL_SCALE;
    end else if (force_duty_enable_r) begin
      adaptive_ratio = forced_duty_value_r;
    end else begin
      case (act_mode_r)
        adaptive_backlight_pwm_pkg::MODE_UI: adaptive_ratio = ui_preferred_level_r[ui_sel_r];
        adaptive_backlight_pwm_pkg::MODE_STILL: adaptive_ratio = content_s_r;
        adaptive_backlight_pwm_pkg::MODE_MOVING: adaptive_ratio = content_s_r;
        default: adaptive_ratio = `ABL_FULL_SCALE;
      endcase
    end
  end

  always_comb begin
    manual_ratio = act_bright_r;
    target = mul_ratio(manual_ratio, adaptive_ratio);
    if (target < min_duty_floor_r) begin
      target = min_duty_floor_r;
    end
    if (!act_backlight_ctrl_enable_r || !sleep_s_r) begin
      target = `ABL_ZERO;
    end
  end

  // Step count chosen by mode; timing chosen by direction.
  always_comb begin
    case (act_mode_r)
      adaptive_backlight_pwm_pkg::MODE_OFF: mode_steps = steps_r[2:0];
      adaptive_backlight_pwm_pkg::MODE_MOVING: mode_steps = steps_r[8:6];
      default: mode_steps = steps_r[5:3];
    endcase
    rising = (target > duty_r);
    fpstep = rising ? timing_r[3:0] : timing_r[7:4];
  end

  // Dimming engine walks the duty linearly toward the target.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dim_state_r <= adaptive_backlight_pwm_pkg::DIM_IDLE;
      duty_r <= `ABL_ZERO;
      step_size_r <= 8'd1;
      frame_cnt_r <= 4'd0;
    end else if (!act_dd_r || (!sleep_s_r && act_mode_r != adaptive_backlight_pwm_pkg::MODE_OFF)) begin
      dim_state_r <= adaptive_backlight_pwm_pkg::DIM_IDLE;
      duty_r <= target;
      frame_cnt_r <= 4'd0;
    end else begin
      case (dim_state_r)
        adaptive_backlight_pwm_pkg::DIM_IDLE: begin
          if (target != duty_r) begin
            dim_state_r <= adaptive_backlight_pwm_pkg::DIM_RAMP;
            frame_cnt_r <= 4'd0;
            if (rising) begin
              step_size_r <= ramp_step(target - duty_r, mode_steps);
            end else begin
              step_size_r <= ramp_step(duty_r - target, mode_steps);
            end
          end
        end
        default: begin
          if (target == duty_r) begin
            dim_state_r <= adaptive_backlight_pwm_pkg::DIM_IDLE;
          end else if (frame_tick) begin
            if (frame_cnt_r + 4'd1 >= fpstep) begin
              frame_cnt_r <= 4'd0;
              if (rising) begin
                duty_r <= (target - duty_r <= step_size_r) ? target : duty_r + step_size_r;
              end else begin
                duty_r <= (duty_r - target <= step_size_r) ? target : duty_r - step_size_r;
              end
            end else begin
              frame_cnt_r <= frame_cnt_r + 4'd1;
            end
          end
        end
      endcase
    end
  end

  function automatic logic [7:0] ramp_step(input logic [7:0] delta, input logic [2:0] steps);
    logic [7:0] q;
    q = (steps == 3'd0) ? delta : delta / {5'd0, steps};
    return (q == 8'd0) ? 8'd1 : q;
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duty_out_r <= `ABL_ZERO;
    end else if (duty_r == `ABL_ZERO) begin
      duty_out_r <= `ABL_ZERO;
    end else begin
      duty_out_r <= sat_add(duty_r, offset_r);
    end
  end

  logic pwm_raw;

  pwm_wave_gen u_wave (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .clock_select_i(pwmcfg_r[1:0]),
    .divider_i(pwm_divider_r),
    .duty_count_i(pwm_count_r),
    .duty_i(duty_out_r),
    .pwm_o(pwm_raw)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      backlight_pwm_out_o <= 1'b0;
      sleep_out_flag_o <= 1'b0;
    end else begin
      backlight_pwm_out_o <= act_gate_r ? (pwm_raw ^ pwmcfg_r[`ABL_PWMCFG_POL_BIT])
                                        : pwmcfg_r[`ABL_PWMCFG_POL_BIT];
      sleep_out_flag_o <= sleep_s_r;
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= `ABL_ZERO;
    end else if (!rd_i) begin
      rdata_o <= `ABL_ZERO;
    end else if (addr_i == `ABL_OFF_BRIGHT_RD) begin
      rdata_o <= duty_r;
    end else if (addr_i == `ABL_OFF_CTRL_RD) begin
      rdata_o <= ctrl_r;
    end else if (addr_i == `ABL_OFF_MODE_RD) begin
      rdata_o <= mode_r;
    end else if (addr_i == `ABL_OFF_MINFLOOR_RD) begin
      rdata_o <= min_duty_floor_r;
    end else if (addr_i == `ABL_OFF_FORCE) begin
      rdata_o <= {7'd0, force_duty_enable_r};
    end else if (addr_i == `ABL_OFF_FORCE_DUTY) begin
      rdata_o <= forced_duty_value_r;
    end else if (addr_i == `ABL_OFF_TIMING) begin
      rdata_o <= timing_r;
    end else if (addr_i == `ABL_OFF_PWMCFG) begin
      rdata_o <= pwmcfg_r;
    end else if (addr_i == `ABL_OFF_PWM_DIVIDER) begin
      rdata_o <= pwm_divider_r;
    end else if (addr_i == `ABL_OFF_ADAPT) begin
      rdata_o <= adaptive_ratio;
    end else if (addr_i == `ABL_OFF_STATUS) begin
      rdata_o <= {6'd0, dim_state_r == adaptive_backlight_pwm_pkg::DIM_RAMP, sleep_s_r};
    end else begin
      rdata_o <= `ABL_ZERO;
    end
  end
endmodule

// ==== verif/adaptive_backlight_pwm_asserts.sv ====
// Port checker of the adaptive backlight block.
`timescale 1ns/1ps
module adaptive_backlight_pwm_asserts (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic frame_start_i,
  input wire logic sleep_out_i,
  input wire logic [7:0] content_ratio_i,
  input wire logic backlight_pwm_out_o,
  input wire logic sleep_out_flag_o
);
  logic [7:0] floor_r;
  logic pol_r;
  logic gate_seen_r;
  logic mapped;
  assign mapped = addr_i inside {[8'h51:8'h56], 8'h5E, 8'h5F, [8'hC0:8'hCD]};
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      floor_r <= 8'h00;
      pol_r <= 1'b0;
      gate_seen_r <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 8'h5E) floor_r <= wdata_i;
      if (addr_i == 8'hC4) pol_r <= wdata_i[2];
      if (addr_i == 8'h53 && wdata_i[2]) gate_seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence pol_settled_s;
    (!gate_seen_r && $stable(pol_r)) [*4];
  endsequence
  sequence floor_read_s;
    rd_i && addr_i == 8'h5F;
  endsequence
  idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero after idle cycle");
  unmapped_rd_a: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  floor_rdback_a: assert property (floor_read_s |=> rdata_o == floor_r)
    else $error("floor readback differs from last write");
  gate_off_pol_a: assert property (pol_settled_s |-> backlight_pwm_out_o == pol_r)
    else $error("ungated pin differs from polarity");
  reset_out_a: assert property ($rose(rst_b_i) |-> !backlight_pwm_out_o && !sleep_out_flag_o)
    else $error("outputs not low after reset");
  flag_rise_a: assert property ($rose(sleep_out_i) |-> ##[1:4] sleep_out_flag_o)
    else $error("sleep flag did not rise");
  flag_fall_a: assert property ($fell(sleep_out_i) |-> ##[1:4] !sleep_out_flag_o)
    else $error("sleep flag did not fall");
  flag_cause_a: assert property ($changed(sleep_out_flag_o) |->
    $past(sleep_out_i, 2) == sleep_out_flag_o || $past(sleep_out_i, 3) == sleep_out_flag_o)
    else $error("sleep flag changed without cause");
endmodule
bind adaptive_backlight_pwm adaptive_backlight_pwm_asserts i_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_start_i(frame_start_i),
  .sleep_out_i(sleep_out_i), .content_ratio_i(content_ratio_i),
  .backlight_pwm_out_o(backlight_pwm_out_o), .sleep_out_flag_o(sleep_out_flag_o));

// ==== verif/led_driver_model.sv ====
// LED driver model that measures pulse width and period at its input.
`timescale 1ns/1ps
module led_driver_model (
  input wire logic clk_sys_i,
  input wire logic pwm_i,
  output int high_o,
  output int period_o
);
  int hi_r = 0;
  int per_r = 0;
  logic last_r = 1'b0;
  initial begin
    high_o = 0;
    period_o = 0;
  end
  always @(posedge clk_sys_i) begin
    last_r <= pwm_i;
    if (pwm_i && !last_r) begin
      high_o <= hi_r;
      period_o <= per_r;
      hi_r <= 1;
      per_r <= 1;
    end else begin
      hi_r <= hi_r + (pwm_i ? 1 : 0);
      per_r <= per_r + 1;
    end
  end
endmodule

// ==== verif/adaptive_backlight_pwm_tb.sv ====
// Self-checking testbench of the adaptive backlight block.
`timescale 1ns/1ps
module adaptive_backlight_pwm_tb;
  logic clk_sys_i, rst_b_i, wr_i, rd_i, frame_start_i, sleep_out_i;
  logic [7:0] addr_i, wdata_i, rdata_o, content_ratio_i, rd_val;
  logic backlight_pwm_out_o, sleep_out_flag_o;
  int high_cnt, period_cnt, n_errors, n_tests;
  adaptive_backlight_pwm i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .frame_start_i(frame_start_i), .sleep_out_i(sleep_out_i),
    .content_ratio_i(content_ratio_i), .backlight_pwm_out_o(backlight_pwm_out_o),
    .sleep_out_flag_o(sleep_out_flag_o));
  led_driver_model i_led (.clk_sys_i(clk_sys_i), .pwm_i(backlight_pwm_out_o),
    .high_o(high_cnt), .period_o(period_cnt));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(name, {8'h00, exp}, {8'h00, rd_val});
  endtask
  task automatic between(input string name, input logic [7:0] lo, input logic [7:0] hi);
    chk(name, 16'h0001, {15'h0000, rd_val > lo && rd_val < hi});
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      frame_start_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      frame_start_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
    end
  endtask
  task automatic t_reset();
    rdc("duty", 8'h52, 8'h00);
    rdc("mode", 8'h56, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    chk("pin", 16'h0000, {15'h0000, backlight_pwm_out_o});
  endtask
  task automatic t_gate_pol();
    wr(8'hC4, 8'h07);
    repeat (4) @(posedge clk_sys_i);
    chk("pin inverted idle", 16'h0001, {15'h0000, backlight_pwm_out_o});
    wr(8'hC4, 8'h03);
    repeat (4) @(posedge clk_sys_i);
    chk("pin idle", 16'h0000, {15'h0000, backlight_pwm_out_o});
  endtask
  task automatic t_manual();
    wr(8'h53, 8'h24);
    wr(8'h51, 8'h80);
    rdc("duty before frame", 8'h52, 8'h00);
    frames(1);
    rdc("manual duty", 8'h52, 8'h80);
    rdc("off ratio", 8'hCC, 8'hFF);
  endtask
  task automatic t_pwm();
    logic [1:0] sel [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
    logic [7:0] div [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
    logic [7:0] cnt [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    int ratio [4] = '{10, 5, 2, 1};
    int per;
    int h0;
    logic half;
    for (int i = 0; i < 6; i++) begin
      wr(8'hC4, {6'h00, sel[i]});
      wr(8'hC5, div[i]);
      wr(8'hC6, cnt[i]);
      per = ratio[sel[i]] * int'(div[i]) * (256 + int'(cnt[i]));
      repeat (3 * per) @(posedge clk_sys_i);
      half = (2 * high_cnt - period_cnt) inside {[-(period_cnt / 32):period_cnt / 32]};
      chk("pwm period", 16'(per), 16'(period_cnt));
      if (cnt[i] == 8'h00) chk("pwm half duty", 16'h0001, {15'h0000, half});
    end
    h0 = high_cnt;
    wr(8'hC6, 8'h00);
    wr(8'hC4, 8'h03);
    wr(8'hC7, 8'h10);
    repeat (768) @(posedge clk_sys_i);
    chk("offset duty", 16'h0010, 16'(high_cnt - h0));
    wr(8'hC7, 8'h00);
    wr(8'hC4, 8'h07);
    repeat (768) @(posedge clk_sys_i);
    chk("inverted duty", 16'(period_cnt - h0), 16'(high_cnt));
    wr(8'hC4, 8'h03);
  endtask
  task automatic t_force();
    wr(8'hC0, 8'h01);
    wr(8'hC1, 8'h40);
    frames(1);
    rdc("forced duty", 8'h52, 8'h20);
    wr(8'hC0, 8'h00);
    frames(1);
    rdc("unforced duty", 8'h52, 8'h80);
  endtask
  task automatic t_modes();
    logic [7:0] exp [3] = '{8'h20, 8'h40, 8'h40};
    wr(8'hCA, 8'h40);
    for (int m = 1; m < 4; m++) begin
      wr(8'h55, 8'(m));
      frames(1);
      rdc("mode readback", 8'h56, 8'(m));
      rdc("adaptive duty", 8'h52, exp[m - 1]);
    end
    @(posedge clk_sys_i);
    content_ratio_i <= 8'h40;
    frames(1);
    rdc("content duty", 8'h52, 8'h20);
    rdc("content ratio", 8'hCC, 8'h40);
    @(posedge clk_sys_i);
    content_ratio_i <= 8'h80;
    wr(8'h55, 8'h00);
    frames(1);
  endtask
  task automatic t_floor();
    wr(8'h51, 8'h10);
    wr(8'h5E, 8'h30);
    frames(1);
    rdc("floored duty", 8'h52, 8'h30);
    rdc("floor readback", 8'h5F, 8'h30);
    wr(8'h5E, 8'h00);
    frames(1);
    rdc("plain duty", 8'h52, 8'h10);
  endtask
  task automatic t_dim();
    wr(8'hC2, 8'h07);
    wr(8'h53, 8'h2C);
    frames(1);
    wr(8'h51, 8'h80);
    frames(2);
    rd(8'h52);
    between("rising ramp", 8'h10, 8'h80);
    frames(10);
    rdc("rising end", 8'h52, 8'h80);
    wr(8'h55, 8'h02);
    frames(3);
    rdc("still single step", 8'h52, 8'h40);
    wr(8'h55, 8'h00);
    frames(12);
    wr(8'h53, 8'h0C);
    frames(2);
    rd(8'h52);
    between("falling ramp", 8'h00, 8'h80);
    frames(12);
    rdc("disabled duty", 8'h52, 8'h00);
  endtask
  task automatic t_sleep();
    wr(8'h53, 8'h24);
    frames(1);
    rdc("awake duty", 8'h52, 8'h80);
    @(posedge clk_sys_i);
    sleep_out_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk("flag asleep", 16'h0000, {15'h0000, sleep_out_flag_o});
    frames(12);
    rdc("asleep duty", 8'h52, 8'h00);
    rdc("asleep status", 8'hCD, 8'h00);
    @(posedge clk_sys_i);
    sleep_out_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk("flag awake", 16'h0001, {15'h0000, sleep_out_flag_o});
    frames(12);
    rdc("woken duty", 8'h52, 8'h80);
    rdc("woken status", 8'hCD, 8'h01);
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    {addr_i, wdata_i, wr_i, rd_i, frame_start_i} = '0;
    sleep_out_i = 1'b1;
    content_ratio_i = 8'h80;
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_gate_pol();
    t_manual();
    t_pwm();
    t_force();
    t_modes();
    t_floor();
    t_dim();
    t_sleep();
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule
